/* rtl/plm_pkg.sv */
// Functional notes
// R01: Regulator 2 enable code: off, on, on while pin low, on while pin high.
// R02: Regulator 2 discharges passively only while off and its discharge bit set.
// R03: Regulator 2 mode bit: 0 linear regulator, 1 load switch.
// R04: Regulator 1 mode bit, bit 0 of its config: 0 linear, 1 switch.
// R05: Monitor off: pulldown when float bit is 0, high impedance when 1.
// R06: Three-bit select routes one rail to the monitor; code 000 disables it.
// R07: Aux output drive code 00 pulls up statically, 01 pulls down statically.
// R08: Drive code 10 follows the control pin, 11 follows its inverse.
// R09: Pull structure: 00 none, 01 down only, 10 up only, 11 push-pull.
// R10: Command writes: power-off code, hard-reset code, separate soft-reset code.
// R11: Regulator 2 voltage is a six-bit code in bits 5..0; upper bits unused.
// R12: Pin-controlled outputs track the control pin level without any new write.
package plm_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_REG1_CFG = 8'h09;
    localparam logic [7:0] IDX_REG2_VOLT = 8'h0A;
    localparam logic [7:0] IDX_REG2_CFG = 8'h0B;
    localparam logic [7:0] IDX_MON_CFG = 8'h0C;
    localparam logic [7:0] IDX_AUX_CFG = 8'h0D;
    localparam logic [7:0] IDX_PWR_CMD = 8'h0E;
    localparam logic [9:0] ADDR_REG1_CFG = {IDX_REG1_CFG, 2'h0};
    localparam logic [9:0] ADDR_REG2_VOLT = {IDX_REG2_VOLT, 2'h0};
    localparam logic [9:0] ADDR_REG2_CFG = {IDX_REG2_CFG, 2'h0};
    localparam logic [9:0] ADDR_MON_CFG = {IDX_MON_CFG, 2'h0};
    localparam logic [9:0] ADDR_AUX_CFG = {IDX_AUX_CFG, 2'h0};
    localparam logic [9:0] ADDR_PWR_CMD = {IDX_PWR_CMD, 2'h0};
    // ------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_REG1_CFG = 8'hF1;
    localparam logic [7:0] MASK_REG2_VOLT = 8'h3F;
    localparam logic [7:0] MASK_REG2_CFG = 8'hE1;
    localparam logic [7:0] MASK_MON_CFG = 8'h0F;
    localparam logic [7:0] MASK_AUX_CFG = 8'hC3;
    localparam logic [7:0] MASK_PWR_CMD = 8'hFF;
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EN_HI = 7;
    localparam int EN_LO = 6;
    localparam int PDSC_BIT = 5;
    localparam int ADSC_BIT = 4;
    localparam int MODE_BIT = 0;
    localparam int VOLT_HI = 5;
    localparam int MON_FLOAT_BIT = 3;
    localparam int MON_SEL_HI = 2;
    localparam int PULL_HI = 1;
    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [1:0] EN_OFF = 2'h0;
    localparam logic [1:0] EN_ON = 2'h1;
    localparam logic [1:0] EN_PIN_LOW = 2'h2;
    localparam logic [1:0] EN_PIN_HIGH = 2'h3;
    localparam logic [1:0] DRV_UP = 2'h0;
    localparam logic [1:0] DRV_DOWN = 2'h1;
    localparam logic [1:0] DRV_PIN = 2'h2;
    localparam logic [1:0] DRV_PIN_INV = 2'h3;
    localparam logic [2:0] MON_OFF = 3'h0;
    localparam logic [7:0] CMD_POWER_OFF = 8'hB2;
    localparam logic [7:0] CMD_HARD_RESET = 8'hC3;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hA5;
endpackage

/* rtl/plm_regs.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module plm_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata_r,
    // Control pin from outside
    input wire logic aux_control_pin,
    // Regulator 1 controls
    output logic [1:0] reg1_on_control_r,
    output logic reg1_off_discharge_r,
    output logic reg1_active_discharge_r,
    output logic reg1_switch_select_r,
    // Regulator 2 controls
    output logic reg2_on_r,
    output logic reg2_discharge_r,
    output logic reg2_switch_select_r,
    output logic [5:0] reg2_voltage_code_r,
    // Monitor mux
    output logic monitor_enable_r,
    output logic [2:0] monitor_rail_select_r,
    output logic monitor_pulldown_r,
    // Aux output drivers
    output logic aux_pull_up_r,
    output logic aux_pull_down_r,
    // Power command strobes
    output logic power_off_r,
    output logic hard_reset_r,
    output logic soft_reset_r
);
    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic pin_meta_r;
    logic pin_sync_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= aux_control_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] reg1_cfg_r;
    logic [7:0] reg2_volt_r;
    logic [7:0] reg2_cfg_r;
    logic [7:0] mon_cfg_r;
    logic [7:0] aux_cfg_r;
    logic [7:0] pwr_cmd_r;
    logic cmd_wr;

    assign cmd_wr = wr && (addr == plm_pkg::ADDR_PWR_CMD);

    // Unused bits are masked at write so they always read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg1_cfg_r <= plm_pkg::RST_VALUE;
            reg2_volt_r <= plm_pkg::RST_VALUE;
            reg2_cfg_r <= plm_pkg::RST_VALUE;
            mon_cfg_r <= plm_pkg::RST_VALUE;
            aux_cfg_r <= plm_pkg::RST_VALUE;
            pwr_cmd_r <= plm_pkg::RST_VALUE;
        end else if (wr) begin
            unique case (addr)
                plm_pkg::ADDR_REG1_CFG: begin
                    reg1_cfg_r <= wdata & plm_pkg::MASK_REG1_CFG;
                end
                plm_pkg::ADDR_REG2_VOLT: begin
                    reg2_volt_r <= wdata & plm_pkg::MASK_REG2_VOLT; // R11
                end
                plm_pkg::ADDR_REG2_CFG: begin
                    reg2_cfg_r <= wdata & plm_pkg::MASK_REG2_CFG;
                end
                plm_pkg::ADDR_MON_CFG: begin
                    mon_cfg_r <= wdata & plm_pkg::MASK_MON_CFG;
                end
                plm_pkg::ADDR_AUX_CFG: begin
                    aux_cfg_r <= wdata & plm_pkg::MASK_AUX_CFG;
                end
                plm_pkg::ADDR_PWR_CMD: begin
                    pwr_cmd_r <= wdata & plm_pkg::MASK_PWR_CMD;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= plm_pkg::RDATA_UNMAPPED;
        end else if (rd) begin
            unique case (addr)
                plm_pkg::ADDR_REG1_CFG: rdata_r <= reg1_cfg_r;
                plm_pkg::ADDR_REG2_VOLT: rdata_r <= reg2_volt_r;
                plm_pkg::ADDR_REG2_CFG: rdata_r <= reg2_cfg_r;
                plm_pkg::ADDR_MON_CFG: rdata_r <= mon_cfg_r;
                plm_pkg::ADDR_AUX_CFG: rdata_r <= aux_cfg_r;
                plm_pkg::ADDR_PWR_CMD: rdata_r <= pwr_cmd_r;
                default: rdata_r <= plm_pkg::RDATA_UNMAPPED;
            endcase
        end else begin
            rdata_r <= plm_pkg::RDATA_UNMAPPED;
        end
    end

    // ------------------------------------------------------------
    // Regulator decode
    // ------------------------------------------------------------
    logic [1:0] reg2_en;
    logic reg2_on_nxt;

    assign reg2_en = reg2_cfg_r[plm_pkg::EN_HI:plm_pkg::EN_LO];

    // Re-evaluated every cycle so the pin is tracked continuously
    always_comb begin
        unique case (reg2_en)
            plm_pkg::EN_OFF: reg2_on_nxt = 1'b0; // R01
            plm_pkg::EN_ON: reg2_on_nxt = 1'b1; // R01
            plm_pkg::EN_PIN_LOW: reg2_on_nxt = ~pin_sync_r; // R01 R12
            plm_pkg::EN_PIN_HIGH: reg2_on_nxt = pin_sync_r; // R01 R12
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg2_on_r <= 1'b0;
            reg2_discharge_r <= 1'b0;
        end else begin
            reg2_on_r <= reg2_on_nxt;
            // Never discharge a live rail
            reg2_discharge_r <= reg2_cfg_r[plm_pkg::PDSC_BIT] & ~reg2_on_nxt; // R02
        end
    end

    // Regulator 1 enable encoding is passed through undecoded
    always_ff @(posedge clk) begin
        if (srst) begin
            reg1_on_control_r <= 2'h0;
            reg1_off_discharge_r <= 1'b0;
            reg1_active_discharge_r <= 1'b0;
            reg1_switch_select_r <= 1'b0;
            reg2_switch_select_r <= 1'b0;
            reg2_voltage_code_r <= 6'h00;
        end else begin
            reg1_on_control_r <= reg1_cfg_r[plm_pkg::EN_HI:plm_pkg::EN_LO];
            reg1_off_discharge_r <= reg1_cfg_r[plm_pkg::PDSC_BIT];
            reg1_active_discharge_r <= reg1_cfg_r[plm_pkg::ADSC_BIT];
            reg1_switch_select_r <= reg1_cfg_r[plm_pkg::MODE_BIT]; // R04
            reg2_switch_select_r <= reg2_cfg_r[plm_pkg::MODE_BIT]; // R03
            reg2_voltage_code_r <= reg2_volt_r[plm_pkg::VOLT_HI:0]; // R11
        end
    end

    // ------------------------------------------------------------
    // Monitor mux
    // ------------------------------------------------------------
    logic [2:0] mon_sel;
    logic mon_on;

    assign mon_sel = mon_cfg_r[plm_pkg::MON_SEL_HI:0];
    assign mon_on = (mon_sel != plm_pkg::MON_OFF);

    always_ff @(posedge clk) begin
        if (srst) begin
            monitor_enable_r <= 1'b0;
            monitor_rail_select_r <= plm_pkg::MON_OFF;
            monitor_pulldown_r <= 1'b0;
        end else begin
            monitor_enable_r <= mon_on; // R06
            monitor_rail_select_r <= mon_sel; // R06
            monitor_pulldown_r <= ~mon_on & ~mon_cfg_r[plm_pkg::MON_FLOAT_BIT]; // R05
        end
    end

    // ------------------------------------------------------------
    // Aux output driver
    // ------------------------------------------------------------
    logic [1:0] aux_drv;
    logic [1:0] aux_pull;
    logic aux_want_up;

    assign aux_drv = aux_cfg_r[plm_pkg::EN_HI:plm_pkg::EN_LO];
    assign aux_pull = aux_cfg_r[plm_pkg::PULL_HI:0];

    always_comb begin
        unique case (aux_drv)
            plm_pkg::DRV_UP: aux_want_up = 1'b1; // R07
            plm_pkg::DRV_DOWN: aux_want_up = 1'b0; // R07
            plm_pkg::DRV_PIN: aux_want_up = pin_sync_r; // R08 R12
            plm_pkg::DRV_PIN_INV: aux_want_up = ~pin_sync_r; // R08 R12
        endcase
    end

    // Pull field gates which of the two drivers may act
    always_ff @(posedge clk) begin
        if (srst) begin
            aux_pull_up_r <= 1'b0;
            aux_pull_down_r <= 1'b0;
        end else begin
            aux_pull_up_r <= aux_want_up & aux_pull[1]; // R09
            aux_pull_down_r <= ~aux_want_up & aux_pull[0]; // R09
        end
    end

    // ------------------------------------------------------------
    // Power command
    // ------------------------------------------------------------
    // Unknown codes are stored for readback but trigger nothing
    always_ff @(posedge clk) begin
        if (srst) begin
            power_off_r <= 1'b0;
            hard_reset_r <= 1'b0;
            soft_reset_r <= 1'b0;
        end else begin
            power_off_r <= cmd_wr && (wdata == plm_pkg::CMD_POWER_OFF); // R10
            hard_reset_r <= cmd_wr && (wdata == plm_pkg::CMD_HARD_RESET); // R10
            soft_reset_r <= cmd_wr && (wdata == plm_pkg::CMD_SOFT_RESET); // R10
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_reg2_cfg_write(logic [1:0] code);
        wr && addr == plm_pkg::ADDR_REG2_CFG && wdata[7:6] == code;
    endsequence

    sequence s_cmd_write(logic [7:0] code);
        wr && addr == plm_pkg::ADDR_PWR_CMD && wdata == code;
    endsequence

    sequence s_reg1_cfg_write;
        wr && addr == plm_pkg::ADDR_REG1_CFG;
    endsequence

    AST_REG2_FORCED_ON: assert property ( // R01
        s_reg2_cfg_write(plm_pkg::EN_ON) ##1 !wr |-> ##1 reg2_on_r)
        else $error("Regulator 2 not on after enable write");

    AST_REG2_PIN_FOLLOW: assert property ( // R01
        reg2_en == plm_pkg::EN_PIN_HIGH && $past(reg2_en) == plm_pkg::EN_PIN_HIGH
        |-> reg2_on_r == $past(pin_sync_r))
        else $error("Regulator 2 does not follow pin");

    AST_REG2_DISCHARGE_OFF: assert property ( // R02
        reg2_discharge_r |-> !reg2_on_r)
        else $error("Discharge while regulator 2 on");

    AST_REG2_DISCHARGE_SET: assert property ( // R02
        !reg2_on_nxt && reg2_cfg_r[plm_pkg::PDSC_BIT] |=> reg2_discharge_r)
        else $error("Discharge missing while off");

    AST_MODE_BITS: assert property ( // R03
        ##1 reg2_switch_select_r == $past(reg2_cfg_r[0])
        && reg1_switch_select_r == $past(reg1_cfg_r[0]))
        else $error("Mode bit not forwarded");

    AST_MON_PULLDOWN: assert property ( // R05
        monitor_pulldown_r |-> !monitor_enable_r && monitor_rail_select_r == plm_pkg::MON_OFF)
        else $error("Pulldown with monitor on");

    AST_MON_ENABLE: assert property ( // R06
        monitor_enable_r == (monitor_rail_select_r != plm_pkg::MON_OFF))
        else $error("Monitor enable mismatch");

    AST_AUX_NO_FIGHT: assert property ( // R09
        !(aux_pull_up_r && aux_pull_down_r))
        else $error("Both aux drivers on");

    AST_AUX_STATIC_UP: assert property ( // R07
        aux_drv == plm_pkg::DRV_UP && aux_pull == 2'h3 |=> aux_pull_up_r)
        else $error("Static pull-up missing");

    AST_AUX_PIN: assert property ( // R08
        aux_drv == plm_pkg::DRV_PIN_INV && aux_pull == 2'h3 && pin_sync_r
        |=> aux_pull_down_r)
        else $error("Inverse pin drive wrong");

    AST_CMD_POWER_OFF: assert property ( // R10
        s_cmd_write(plm_pkg::CMD_POWER_OFF) |=> power_off_r
        ##1 (!power_off_r || $past(cmd_wr) && $past(wdata) == plm_pkg::CMD_POWER_OFF))
        else $error("Power-off strobe wrong");

    AST_CMD_HARD_ONLY: assert property ( // R10
        s_cmd_write(plm_pkg::CMD_HARD_RESET) |=> hard_reset_r && !power_off_r && !soft_reset_r)
        else $error("Hard reset strobe wrong");

    AST_VOLT_CODE: assert property ( // R11
        wr && addr == plm_pkg::ADDR_REG2_VOLT ##1 !wr
        |=> reg2_voltage_code_r == $past(wdata[5:0], 2))
        else $error("Voltage code not applied");

    AST_REG1_SWITCH: assert property ( // R04
        s_reg1_cfg_write ##1 !wr
        |=> reg1_switch_select_r == $past(wdata[plm_pkg::MODE_BIT], 2))
        else $error("Regulator 1 mode bit not applied");

    AST_REG2_PIN_LOW: assert property ( // R01
        reg2_en == plm_pkg::EN_PIN_LOW && $past(reg2_en) == plm_pkg::EN_PIN_LOW
        |-> reg2_on_r == !$past(pin_sync_r))
        else $error("Regulator 2 does not follow inverse pin");

    AST_REG2_NO_DISCHARGE: assert property ( // R02
        !reg2_cfg_r[plm_pkg::PDSC_BIT] |=> !reg2_discharge_r)
        else $error("Discharge with discharge bit clear");

    AST_MON_FLOAT: assert property ( // R05
        mon_sel == plm_pkg::MON_OFF
        |=> monitor_pulldown_r == !$past(mon_cfg_r[plm_pkg::MON_FLOAT_BIT]))
        else $error("Monitor off termination wrong");

    AST_AUX_STATIC_DOWN: assert property ( // R07
        aux_drv == plm_pkg::DRV_DOWN && aux_pull[0]
        |=> aux_pull_down_r && !aux_pull_up_r)
        else $error("Static pull-down missing");

    AST_AUX_PULL_NONE: assert property ( // R09
        aux_pull == 2'h0 |=> !aux_pull_up_r && !aux_pull_down_r)
        else $error("Aux driver active with pull disabled");

    AST_AUX_UP_ONLY: assert property ( // R09
        aux_pull == 2'h2 |=> !aux_pull_down_r)
        else $error("Pull-down active in pull-up only mode");

    // Pin level alone must move the driver, with no write in between
    AST_AUX_TRACK: assert property ( // R12
        aux_drv == plm_pkg::DRV_PIN && aux_pull == 2'h3
        |=> aux_pull_up_r == $past(pin_sync_r))
        else $error("Aux output does not track pin");

    AST_CMD_SOFT_ONLY: assert property ( // R10
        s_cmd_write(plm_pkg::CMD_SOFT_RESET)
        |=> soft_reset_r && !power_off_r && !hard_reset_r)
        else $error("Soft reset strobe wrong");

    AST_CMD_QUIET: assert property ( // R10
        !cmd_wr |=> !power_off_r && !hard_reset_r && !soft_reset_r)
        else $error("Command strobe without write");

    AST_VOLT_UPPER_ZERO: assert property ( // R11
        rd && addr == plm_pkg::ADDR_REG2_VOLT |=> rdata_r[7:6] == 2'h0)
        else $error("Voltage register upper bits not zero");

endmodule

/* sim/plm_regs_tb.sv */
`timescale 1ns/1ps
module plm_regs_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pin = 1'b0;
    logic [7:0] rdata_r;
    logic [1:0] reg1_on_control_r;
    logic reg1_off_discharge_r, reg1_active_discharge_r, reg1_switch_select_r;
    logic reg2_on_r, reg2_discharge_r, reg2_switch_select_r;
    logic [5:0] reg2_voltage_code_r;
    logic monitor_enable_r, monitor_pulldown_r;
    logic [2:0] monitor_rail_select_r;
    logic aux_pull_up_r, aux_pull_down_r, power_off_r, hard_reset_r, soft_reset_r;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h000007E8;
    logic [7:0] sh [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #5 clk = ~clk;

    plm_regs plm_regs_i (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r), .aux_control_pin(pin),
        .reg1_on_control_r(reg1_on_control_r), .reg1_off_discharge_r(reg1_off_discharge_r),
        .reg1_active_discharge_r(reg1_active_discharge_r),
        .reg1_switch_select_r(reg1_switch_select_r), .reg2_on_r(reg2_on_r),
        .reg2_discharge_r(reg2_discharge_r), .reg2_switch_select_r(reg2_switch_select_r),
        .reg2_voltage_code_r(reg2_voltage_code_r), .monitor_enable_r(monitor_enable_r),
        .monitor_rail_select_r(monitor_rail_select_r), .monitor_pulldown_r(monitor_pulldown_r),
        .aux_pull_up_r(aux_pull_up_r), .aux_pull_down_r(aux_pull_down_r),
        .power_off_r(power_off_r), .hard_reset_r(hard_reset_r), .soft_reset_r(soft_reset_r)
    );

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [9:0] addr_of(input int k);
        case (k)
            0: return plm_pkg::ADDR_REG1_CFG;
            1: return plm_pkg::ADDR_REG2_VOLT;
            2: return plm_pkg::ADDR_REG2_CFG;
            3: return plm_pkg::ADDR_MON_CFG;
            4: return plm_pkg::ADDR_AUX_CFG;
            default: return 10'h040;
        endcase
    endfunction

    function automatic logic [7:0] mask_of(input int k);
        case (k)
            0: return 8'hF1;
            1: return 8'h3F;
            2: return 8'hE1;
            3: return 8'h0F;
            default: return 8'hC3;
        endcase
    endfunction

    function automatic logic exp_on(input logic [7:0] c, input logic p);
        case (c[7:6])
            2'h0: return 1'b0;
            2'h1: return 1'b1;
            2'h2: return ~p;
            default: return p;
        endcase
    endfunction

    // Wanted level first, then the pull field decides which driver may act
    function automatic logic [1:0] exp_aux(input logic [7:0] a, input logic p);
        logic up;
        up = (a[7:6] == 2'h0) | ((a[7:6] == 2'h2) & p) | ((a[7:6] == 2'h3) & ~p);
        return {up & a[1], ~up & a[0]};
    endfunction

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input logic w, input logic r, input logic [9:0] a, input logic [7:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d);
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand one cycle only, then fall back to zero
    task automatic rd_tail(input logic [7:0] exp);
        rd <= 1'b0;
        #1;
        check(rdata_r, exp);
        @(posedge clk);
        #1;
        check(rdata_r, 8'h00);
    endtask

    task automatic wr_rd(input logic [9:0] a, input logic [7:0] d, input logic [7:0] exp);
        cyc(1'b1, 1'b0, a, d);
        cyc(1'b0, 1'b1, a, 8'h00);
        rd_tail(exp);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic check_outputs();
        check({reg1_on_control_r, reg1_off_discharge_r, reg1_active_discharge_r, 3'h0,
               reg1_switch_select_r}, sh[0]);
        check(8'(reg2_on_r), 8'(exp_on(sh[2], pin)));
        check(8'(reg2_discharge_r), 8'(sh[2][5] & ~exp_on(sh[2], pin)));
        check(8'(reg2_switch_select_r), 8'(sh[2][0]));
        check(8'(reg2_voltage_code_r), 8'(sh[1][5:0]));
        check({4'h0, monitor_enable_r, monitor_rail_select_r},
              {4'h0, sh[3][2:0] != 3'h0, sh[3][2:0]});
        check(8'(monitor_pulldown_r), 8'((sh[3][2:0] == 3'h0) & ~sh[3][3]));
        check(8'({aux_pull_up_r, aux_pull_down_r}), 8'(exp_aux(sh[4], pin)));
        check(8'({power_off_r, hard_reset_r, soft_reset_r}), 8'h00);
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 2150 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0] c;
        logic [5:0] v;
        logic [9:0] a;
        int k;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            cyc(1'b0, 1'b1, addr_of(i), 8'h00);
            rd_tail(8'h00);
        end
        settle();
        check_outputs();
        $display("test reset values done");
        for (int i = 0; i < 64; i++) begin
            v = i[5:0];
            sh[2] = {v[2:1], v[3], 4'h0, v[4]};
            sh[4] = {v[2:1], 4'h0, v[4:3]};
            sh[3] = {4'h0, v[0], v[5:3]};
            pin <= v[0];
            wr_reg(addr_of(2), sh[2]);
            wr_reg(addr_of(4), sh[4]);
            wr_reg(addr_of(3), sh[3]);
            settle();
            check_outputs();
            pin <= ~v[0];
            settle();
            check_outputs();
        end
        $display("test code table done");
        for (int i = 0; i < 5; i++) begin
            c = (i == 0) ? 8'hB2 : (i == 1) ? 8'hC3 : (i == 2) ? 8'hA5 : (i == 3) ? 8'h00 : 8'hB3;
            wr_reg(plm_pkg::ADDR_PWR_CMD, c);
            check(8'({power_off_r, hard_reset_r, soft_reset_r}),
                  8'({c == 8'hB2, c == 8'hC3, c == 8'hA5}));
            @(posedge clk);
            #1;
            check(8'({power_off_r, hard_reset_r, soft_reset_r}), 8'h00);
            cyc(1'b0, 1'b1, plm_pkg::ADDR_PWR_CMD, 8'h00);
            rd_tail(c);
        end
        cyc(1'b1, 1'b0, plm_pkg::ADDR_PWR_CMD, 8'hB2);
        wr_reg(plm_pkg::ADDR_PWR_CMD, 8'hC3);
        check(8'({power_off_r, hard_reset_r, soft_reset_r}), 8'h02);
        $display("test power commands done");
        repeat (200) begin
            r = rnd();
            k = int'(r % 32'h00000006);
            c = r[15:8];
            a = addr_of(k);
            if (k == 5 && r[16]) begin
                a = plm_pkg::ADDR_REG2_CFG + 10'h001;
            end
            if (k < 5) begin
                sh[k] = c & mask_of(k);
            end
            wr_rd(a, c, (k < 5) ? sh[k] : 8'h00);
            pin <= r[20];
            settle();
            check_outputs();
        end
        $display("test random traffic done");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        sh = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        settle();
        check_outputs();
        $display("test second reset done");
        wrap_up();
    end
endmodule
